// ===== dcpr_ctrl_model.sv
// Controller-side model driving the link clock and command pins
`timescale 1ns/1ps
module dcpr_ctrl_model (
	// Link clock
	output logic                        link_ck,
	// Command pins
	output logic                        cs_n,
	output logic                        ras_n,
	output logic                        cas_n,
	output logic                        we_n,
	output logic [dcpr_pkg::BA_W-1:0]   ba,
	output logic [dcpr_pkg::ADDR_W-1:0] addr
);
	import dcpr_pkg::*;

	time cmd_t;

	// ------------
	// Link clock
	// ------------
	// Offset 1 ns so no link edge meets a system clock edge
	initial begin
		link_ck = 1'b0;
		#1;
		forever #32 link_ck = ~link_ck;
	end

	initial begin
		{cs_n, ras_n, cas_n, we_n} = 4'hF;
		ba    = '0;
		addr  = '0;
		cmd_t = 0;
	end

	// ------------
	// Command tasks
	// ------------
	task automatic issue(input logic [3:0] code, input logic [2:0] b,
		input logic [13:0] a);
		@(negedge link_ck);
		{cs_n, ras_n, cas_n, we_n} <= code;
		ba   <= b;
		addr <= a;
		@(posedge link_ck);
		cmd_t = $time;
		@(negedge link_ck);
		{cs_n, ras_n, cas_n, we_n} <= 4'hF;
		// Released pins must not keep the last value
		ba   <= ~b;
		addr <= ~a;
	endtask

	task automatic mode_load(input logic [2:0] b, input logic [13:0] v);
		repeat (2) @(posedge link_ck);
		issue(4'h0, b, v);
		repeat (2) @(posedge link_ck);
	endtask

	// No write task exists: only reads while the pattern mode is on
	task automatic pattern_rd(input logic [2:0] b, input logic [13:0] a);
		issue(4'h5, b, {a[13:2], 2'h0});
	endtask
endmodule

// ===== dcpr_latency_line.sv
// Shift line holding pending pattern reads, tapped at the read latency
`timescale 1ns/1ps
module dcpr_latency_line #(
	parameter int DEPTH = 24,
	parameter int W     = 3
) (
	// System side
	input  wire logic                     clock,
	input  wire logic                     rstn,
	// Shift on each link rising edge
	input  wire logic                     shift,
	input  wire logic [W-1:0]             din,
	// Tap selects the entry one link cycle short of due
	input  wire logic [$clog2(DEPTH)-1:0] tap_sel,
	output logic      [W-1:0]             tap
);

	logic [W-1:0] line      [DEPTH];
	logic [W-1:0] next_line [DEPTH];

	generate
		if (DEPTH < 2)
			$error("dcpr_latency_line: DEPTH below 2");
	endgenerate

	always_comb begin
		next_line[0] = shift ? din : line[0];
		for (int i = 1; i < DEPTH; i++) begin
			next_line[i] = shift ? line[i-1] : line[i];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < DEPTH; i++) begin
				line[i] <= '0;
			end
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				line[i] <= next_line[i];
			end
		end
	end

	// Out-of-range select reads as no pending read
	assign tap = (int'(tap_sel) < DEPTH) ? line[tap_sel] : '0;

endmodule

// ===== dcpr_pkg.sv
// Shared constants for the calibration pattern readout block
package dcpr_pkg;

	// ----------------------------------------------------------------
	// Pin and mode register geometry
	// ----------------------------------------------------------------
	localparam int BA_W     = 3;
	localparam int ADDR_W   = 14;
	localparam int MR_COUNT = 4;
	localparam int PIN_W    = 1 + 4 + BA_W + ADDR_W;

	// mode_reg_three fields
	localparam int          MR3_ENABLE_BIT  = 2;
	localparam int          MR3_SEL_LSB     = 0;
	localparam logic [1:0]  SEL_PATTERN     = 2'h0;

	// mode_reg_zero fields: burst mode and column latency code
	localparam int          MR0_BL_LSB      = 0;
	localparam logic [1:0]  BL_FIXED8       = 2'h0;
	localparam logic [1:0]  BL_OTF          = 2'h1;
	localparam logic [1:0]  BL_FIXED4       = 2'h2;
	localparam int          MR0_CL_LSB      = 4;
	localparam logic [4:0]  CL_BASE         = 5'h05;

	// mode_reg_one field: additive latency code
	localparam int          MR1_AL_LSB      = 3;

	// Address bits that matter on a pattern read
	localparam int          ADDR_HALF_BIT   = 2;
	localparam int          ADDR_CHOP_BIT   = 12;

	// Burst positions 0..7, position 0 in the LSB
	localparam logic [7:0]  PATTERN         = 8'hAA;
	localparam logic [3:0]  BEATS_FULL      = 4'h8;
	localparam logic [3:0]  BEATS_CHOP      = 4'h4;

	// ----------------------------------------------------------------
	// Timing, 4 ns system clock, least times rounded up
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS         = 4000;
	localparam int MODE_SPACING_NS       = 16;
	localparam int MODE_UPDATE_NS        = 24;
	localparam int PATTERN_RECOVERY_NS   = 8;
	localparam int PRECHARGE_NS          = 14;
	localparam int MODE_SPACING_CYC      =
		(MODE_SPACING_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int MODE_UPDATE_CYC       =
		(MODE_UPDATE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PATTERN_RECOVERY_CYC  =
		(PATTERN_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PRECHARGE_CYC         =
		(PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ----------------------------------------------------------------
	// Register port map (word indices)
	// ----------------------------------------------------------------
	localparam int          REG_ADDR_W   = 3;
	localparam int          REG_DATA_W   = 16;
	localparam logic [2:0]  REG_MODE0    = 3'h0;
	localparam logic [2:0]  REG_MODE1    = 3'h1;
	localparam logic [2:0]  REG_MODE2    = 3'h2;
	localparam logic [2:0]  REG_MODE3    = 3'h3;
	localparam logic [2:0]  REG_CTRL     = 3'h4;
	localparam logic [2:0]  REG_STATUS   = 3'h5;
	localparam int          CTRL_ALL_BIT = 0;
	localparam logic        CTRL_RESET   = 1'b0;
	localparam logic [13:0] MODE_RESET   = 14'h0000;

	typedef enum logic [1:0] {
		CMD_NOP,
		CMD_MODE_LOAD,
		CMD_READ,
		CMD_OTHER
	} dcpr_cmd_t;

	typedef enum logic {
		BURST_IDLE,
		BURST_RUN
	} dcpr_burst_t;

endpackage

// ===== dcpr_readout.sv
// Calibration pattern readout with mode load decode, device side
//
// Contract
// - Pattern goes on the prime lane of each byte, others low, or all lanes.
// - Both eight-beat bursts and four-beat chop, chop by mode or per command.
// - Chop returns beats zero to three, or four to seven when bit two set.
// - Burst position zero maps to LSB, position seven to MSB.
// - Column bits nine to three, ten, eleven, thirteen, bank bits ignored.
// - Address bit twelve picks chop only when per-command select enabled.
// - Pattern is always alternating zero-one for eight or four beats.
// - Selector zero picks the pattern; other selector values give no readout.
// - Pattern burst starts additive plus column latency after the read.
// - Exit waits read recovery, then enable cleared restores array access; the recovery count only shows in status, exit is not held off.
// - Mode load writes the address value into the register picked by bank.
// - New mode functions apply only after the mode update delay.
// - Enable set returns pattern data for reads; clear means normal operation.
`timescale 1ns/1ps
module dcpr_readout
#(
	parameter int DQ_W   = 16,
	parameter int MAX_RL = 24
) (
	// System
	input  wire logic                     clock,
	input  wire logic                     rstn,
	// Link command pins, asynchronous to clock
	input  wire logic                     link_ck,
	input  wire logic                     cs_n,
	input  wire logic                     ras_n,
	input  wire logic                     cas_n,
	input  wire logic                     we_n,
	input  wire logic [dcpr_pkg::BA_W-1:0]   ba,
	input  wire logic [dcpr_pkg::ADDR_W-1:0] addr,
	// Data lanes, output side of the two-way pins
	output logic      [DQ_W-1:0]          dq_out,
	output logic                          dq_oe,
	// Register port
	input  wire logic [dcpr_pkg::REG_ADDR_W-1:0] reg_addr,
	input  wire logic [dcpr_pkg::REG_DATA_W-1:0] reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [dcpr_pkg::REG_DATA_W-1:0] reg_rdata
);
	import dcpr_pkg::*;

	localparam int TAP_W = $clog2(MAX_RL);

	generate
		if (DQ_W % 8 != 0 || DQ_W < 8)
			$error("dcpr_readout: DQ_W must be whole bytes");
		if (MAX_RL < 24)
			$error("dcpr_readout: MAX_RL too small for longest latency");
	endgenerate

	// ----------------------------------------------------------------
	// Pin capture and link edge detect
	// ----------------------------------------------------------------
	logic [PIN_W-1:0] pins_s;
	logic             ck_s;
	logic             ck_prev;
	logic [3:0]       cmd_s;
	logic [BA_W-1:0]  ba_s;
	logic [ADDR_W-1:0] addr_s;
	logic             ck_rise;
	logic             ck_fall;

	dcpr_sync #(
		.W       (PIN_W),
		.RST_VAL ({1'b0, 4'hF, {(BA_W + ADDR_W){1'b0}}})
	) u_sync (
		.clock (clock),
		.rstn  (rstn),
		.pin   ({link_ck, cs_n, ras_n, cas_n, we_n, ba, addr}),
		.sync  (pins_s)
	);

	assign {ck_s, cmd_s, ba_s, addr_s} = pins_s;
	assign ck_rise = ck_s & ~ck_prev;
	assign ck_fall = ~ck_s & ck_prev;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ck_prev <= 1'b0;
		end else begin
			ck_prev <= ck_s;
		end
	end

	function automatic dcpr_cmd_t decode_cmd(input logic [3:0] c);
		case (c)
			4'h0:    decode_cmd = CMD_MODE_LOAD;
			4'h5:    decode_cmd = CMD_READ;
			default: decode_cmd = c[3] ? CMD_NOP : CMD_OTHER;
		endcase
	endfunction

	function automatic logic [4:0] read_latency(input logic [13:0] m0,
		input logic [13:0] m1);
		logic [4:0] cl;
		cl = CL_BASE + {2'b00, m0[MR0_CL_LSB +: 3]};
		case (m1[MR1_AL_LSB +: 2])
			2'h1:    read_latency = cl + cl - 5'h01;
			2'h2:    read_latency = cl + cl - 5'h02;
			default: read_latency = cl;
		endcase
	endfunction

	dcpr_cmd_t cmd;
	assign cmd = ck_rise ? decode_cmd(cmd_s) : CMD_NOP;

	// ----------------------------------------------------------------
	// Mode registers and load delays
	// ----------------------------------------------------------------
	logic [13:0] mode_reg      [MR_COUNT];
	logic [13:0] next_mode_reg [MR_COUNT];
	logic [13:0] pend_val,  next_pend_val;
	logic [1:0]  pend_idx,  next_pend_idx;
	logic        pend_on,   next_pend_on;
	logic [7:0]  mod_cnt,   next_mod_cnt;
	logic [7:0]  mrd_cnt,   next_mrd_cnt;
	logic        all_lanes, next_all_lanes;
	logic        mrs_acc;
	logic        apply;

	// Bank value 1xx names no register here, so the load is dropped
	assign mrs_acc = (cmd == CMD_MODE_LOAD) && !ba_s[2];
	assign apply   = pend_on && mod_cnt == 8'h01;

	always_comb begin
		next_mode_reg  = mode_reg;
		next_pend_val  = pend_val;
		next_pend_idx  = pend_idx;
		next_pend_on   = pend_on;
		next_mod_cnt   = (mod_cnt != 8'h00) ? mod_cnt - 8'h01 : 8'h00;
		next_mrd_cnt   = (mrd_cnt != 8'h00) ? mrd_cnt - 8'h01 : 8'h00;
		next_all_lanes = all_lanes;
		if (apply) begin
			next_mode_reg[pend_idx] = pend_val;
			next_pend_on = 1'b0;
		end
		// A load during another's update delay replaces it
		if (mrs_acc) begin
			next_pend_val = addr_s;
			next_pend_idx = ba_s[1:0];
			next_pend_on  = 1'b1;
			next_mod_cnt  = 8'(MODE_UPDATE_CYC);
			next_mrd_cnt  = 8'(MODE_SPACING_CYC);
		end
		if (reg_wr && reg_addr == REG_CTRL) begin
			next_all_lanes = reg_wdata[CTRL_ALL_BIT];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < MR_COUNT; i++) begin
				mode_reg[i] <= MODE_RESET;
			end
			pend_val  <= MODE_RESET;
			pend_idx  <= 2'h0;
			pend_on   <= 1'b0;
			mod_cnt   <= 8'h00;
			mrd_cnt   <= 8'h00;
			all_lanes <= CTRL_RESET;
		end else begin
			mode_reg  <= next_mode_reg;
			pend_val  <= next_pend_val;
			pend_idx  <= next_pend_idx;
			pend_on   <= next_pend_on;
			mod_cnt   <= next_mod_cnt;
			mrd_cnt   <= next_mrd_cnt;
			all_lanes <= next_all_lanes;
		end
	end

	// ----------------------------------------------------------------
	// Pattern read acceptance and latency line
	// ----------------------------------------------------------------
	logic       mpr_active;
	logic       sel_reserved;
	logic [1:0] bl_mode;
	logic       rd_chop;
	logic       rd_half;
	logic       read_acc;
	logic [2:0] tap;
	logic [4:0] rl;

	assign mpr_active   = mode_reg[3][MR3_ENABLE_BIT];
	assign sel_reserved = mode_reg[3][MR3_SEL_LSB +: 2] != SEL_PATTERN;
	assign bl_mode      = mode_reg[0][MR0_BL_LSB +: 2];
	assign rl           = read_latency(mode_reg[0], mode_reg[1]);
	// Address bit twelve low means chop, only under per-command select
	assign rd_chop = (bl_mode == BL_OTF) ? !addr_s[ADDR_CHOP_BIT]
		: (bl_mode == BL_FIXED4);
	// Only bits two and twelve are looked at on a pattern read
	assign rd_half = rd_chop && addr_s[ADDR_HALF_BIT];
	assign read_acc = (cmd == CMD_READ) && mpr_active
		&& !sel_reserved;

	dcpr_latency_line #(
		.DEPTH (MAX_RL),
		.W     (3)
	) u_line (
		.clock   (clock),
		.rstn    (rstn),
		.shift   (ck_rise),
		.din     ({read_acc, rd_chop, rd_half}),
		.tap_sel (TAP_W'(rl - 5'h01)),
		.tap     (tap)
	);

	// ----------------------------------------------------------------
	// Burst engine, one beat on every link edge
	// ----------------------------------------------------------------
	logic [DQ_W-1:0] prime_mask;
	logic [DQ_W-1:0] lane_set;
	dcpr_burst_t     state, next_state;
	logic [2:0]      beat_idx, next_beat_idx;
	logic [3:0]      beats_left, next_beats_left;
	logic [DQ_W-1:0] next_dq_out;
	logic            next_dq_oe;
	logic [7:0]      mprr_cnt, next_mprr_cnt;
	logic            start;
	logic            burst_end;
	logic [2:0]      cur_idx;
	logic [3:0]      cur_left;

	genvar g;
	generate
		for (g = 0; g < DQ_W / 8; g++) begin : g_byte
			assign prime_mask[g*8 +: 8] = 8'h01;
		end
	endgenerate

	assign lane_set = all_lanes ? {DQ_W{1'b1}} : prime_mask;
	assign start    = ck_rise && tap[2];

	always_comb begin
		cur_idx  = start ? {tap[0], 2'b00} : beat_idx;
		cur_left = start ? (tap[1] ? BEATS_CHOP : BEATS_FULL) : beats_left;
		next_beat_idx   = beat_idx;
		next_beats_left = start ? cur_left : beats_left;
		next_dq_out     = dq_out;
		next_dq_oe      = dq_oe;
		next_mprr_cnt   = (mprr_cnt != 8'h00) ? mprr_cnt - 8'h01 : 8'h00;
		burst_end       = 1'b0;
		if (ck_rise || ck_fall) begin
			if (cur_left != 4'h0) begin
				// LSB of the pattern is burst position zero
				next_dq_out     = PATTERN[cur_idx] ? lane_set : '0;
				next_dq_oe      = 1'b1;
				next_beat_idx   = cur_idx + 3'h1;
				next_beats_left = cur_left - 4'h1;
				burst_end       = cur_left == 4'h1;
			end else begin
				next_dq_out = '0;
				next_dq_oe  = 1'b0;
			end
		end
		if (burst_end) begin
			next_mprr_cnt = 8'(PATTERN_RECOVERY_CYC);
		end
		case (state)
			BURST_IDLE: next_state = start ? BURST_RUN : BURST_IDLE;
			BURST_RUN:  next_state = (next_beats_left != 4'h0 || next_dq_oe)
				? BURST_RUN : BURST_IDLE;
			default:    next_state = BURST_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state      <= BURST_IDLE;
			beat_idx   <= 3'h0;
			beats_left <= 4'h0;
			dq_out     <= '0;
			dq_oe      <= 1'b0;
			mprr_cnt   <= 8'h00;
		end else begin
			state      <= next_state;
			beat_idx   <= next_beat_idx;
			beats_left <= next_beats_left;
			dq_out     <= next_dq_out;
			dq_oe      <= next_dq_oe;
			mprr_cnt   <= next_mprr_cnt;
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	logic [REG_DATA_W-1:0] next_reg_rdata;
	logic [4:0]            status;

	assign status = {state == BURST_RUN, mprr_cnt != 8'h00,
		mrd_cnt != 8'h00, pend_on, mpr_active};

	always_comb begin
		next_reg_rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				REG_MODE0, REG_MODE1, REG_MODE2, REG_MODE3:
					next_reg_rdata = {2'b00, mode_reg[reg_addr[1:0]]};
				REG_CTRL:   next_reg_rdata = {15'h0000, all_lanes};
				REG_STATUS: next_reg_rdata = {11'h000, status};
				default:    next_reg_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= next_reg_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence mrs_then_quiet;
		mrs_acc ##1 (!mrs_acc)[*5];
	endsequence

	chk_prime_lanes_low: assert property (
		dq_oe && !all_lanes |-> (dq_out & ~prime_mask) == '0)
		else $error("non-prime lane driven high");
	chk_all_lanes_equal: assert property (
		dq_oe && all_lanes |-> dq_out == {DQ_W{dq_out[0]}})
		else $error("lanes disagree in all-lane mode");
	chk_first_beat_low: assert property (
		start |=> dq_oe && !dq_out[0])
		else $error("first pattern beat not zero");
	chk_reserved_silent: assert property (
		cmd == CMD_READ && sel_reserved |=> !u_line.line[0][2])
		else $error("read taken with reserved selector");
	chk_array_mode_idle: assert property (
		cmd == CMD_READ && !mpr_active |=> !u_line.line[0][2])
		else $error("pattern read taken with mode off");
	chk_read_to_burst: assert property (
		read_acc |-> ##[1:500] start)
		else $error("pattern burst never started");
	chk_mode_update_wait: assert property (
		mrs_then_quiet |=> apply)
		else $error("mode update delay wrong");
	chk_mode_target: assert property (
		apply |=> mode_reg[$past(pend_idx)] == $past(pend_val))
		else $error("mode load written to wrong register");
	chk_fixed_full_burst: assert property (
		cmd == CMD_READ && bl_mode == BL_FIXED8 |=> !u_line.line[0][1])
		else $error("chop taken under fixed eight-beat mode");

endmodule

// ===== dcpr_sync.sv
// Two-stage synchroniser for a bundle of link pins
`timescale 1ns/1ps
module dcpr_sync #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// System side
	input  wire logic         clock,
	input  wire logic         rstn,
	// Pins in, synchronised out
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] sync
);

	logic [W-1:0] stage_one;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			stage_one <= RST_VAL;
			sync      <= RST_VAL;
		end else begin
			stage_one <= pin;
			sync      <= stage_one;
		end
	end

endmodule

// ===== tb_top.sv
// Self-checking bench for the calibration pattern readout block
`timescale 1ns/1ps
module tb_top;
	import dcpr_pkg::*;

	logic        clock;
	logic        rstn;
	logic        link_ck;
	logic        cs_n;
	logic        ras_n;
	logic        cas_n;
	logic        we_n;
	logic [2:0]  ba;
	logic [13:0] addr;
	logic [15:0] dq_out;
	logic        dq_oe;
	logic [2:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	int          error_cnt;
	int          checked;

	dcpr_ctrl_model ctrl (.link_ck(link_ck), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));

	dcpr_readout #(.DQ_W(16), .MAX_RL(24)) DUT (.clock(clock), .rstn(rstn),
		.link_ck(link_ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
		.we_n(we_n), .ba(ba), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));

	initial clock = 1'b0;
	always #2 clock = ~clock;

	// ------------
	// Shared tasks
	// ------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [2:0] a, output logic [15:0] d);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// Zero beats means no burst may show within the window
	task automatic pattern_read(input logic [13:0] a, input int beats,
		input int rl, input logic all);
		int          n;
		int          lat;
		logic [15:0] lane;
		ctrl.pattern_rd(3'h7, a);
		n = 0;
		while (dq_oe !== 1'b1 && n < 16 * (rl + 3)) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (beats == 0) begin
			check({15'h0, dq_oe}, 16'h0000);
			return;
		end
		lat = int'(($time - ctrl.cmd_t) / 4);
		check(16'(lat >= 16 * rl && lat <= 16 * rl + 6), 16'h1);
		lane = all ? 16'hFFFF : 16'h0101;
		repeat (4) @(posedge clock);
		for (int i = 0; i < beats; i++) begin
			#1 check(dq_out, (i % 2) ? lane : 16'h0000);
			repeat (8) @(posedge clock);
		end
		#1 check({15'h0, dq_oe}, 16'h0000);
	endtask

	// ------------
	// Scenarios
	// ------------
	task automatic t_reset_regs;
		logic [15:0] d;
		for (int a = 0; a < 7; a++) begin
			reg_read(3'(a), d);
			check(d, 16'h0000);
		end
		@(posedge clock);
		#1 check(reg_rdata, 16'h0000);
		check({15'h0, dq_oe}, 16'h0000);
		reg_write(REG_MODE0, 16'h0FFF);
		reg_read(REG_MODE0, d);
		check(d, 16'h0000);
		reg_write(REG_CTRL, 16'h0001);
		reg_read(REG_CTRL, d);
		check(d, 16'h0001);
		reg_write(REG_CTRL, 16'h0000);
	endtask

	task automatic t_mode_select;
		logic [15:0] d;
		for (int b = 0; b < 4; b++)
			ctrl.mode_load(3'(b), 14'h1000 | 14'(b));
		for (int b = 0; b < 4; b++) begin
			reg_read(3'(b), d);
			check(d, 16'h1000 | 16'(b));
		end
		ctrl.mode_load(3'h4, 14'h3FFF);
		reg_read(REG_MODE0, d);
		check(d, 16'h1000);
		ctrl.mode_load(3'h0, 14'h0000);
		ctrl.mode_load(3'h1, 14'h0000);
		ctrl.mode_load(3'h3, 14'h0004);
		reg_read(REG_STATUS, d);
		check({15'h0, d[0]}, 16'h0001);
	endtask

	task automatic t_full_burst;
		pattern_read(14'h2FF8, 8, 5, 1'b0);
		pattern_read(14'h0000, 8, 5, 1'b0);
		reg_write(REG_CTRL, 16'h0001);
		pattern_read(14'h0000, 8, 5, 1'b1);
		reg_write(REG_CTRL, 16'h0000);
	endtask

	task automatic t_chop;
		ctrl.mode_load(3'h0, 14'(BL_FIXED4));
		pattern_read(14'h0000, 4, 5, 1'b0);
		pattern_read(14'h0004, 4, 5, 1'b0);
		ctrl.mode_load(3'h0, 14'(BL_OTF));
		pattern_read(14'h1000, 8, 5, 1'b0);
		pattern_read(14'h0000, 4, 5, 1'b0);
		pattern_read(14'h0004, 4, 5, 1'b0);
	endtask

	// Column latency 6; additive codes 0..3 give 0, CL-1, CL-2, 0
	task automatic t_latency;
		int al [4] = '{0, 5, 4, 0};
		ctrl.mode_load(3'h0, 14'h0010);
		for (int c = 0; c < 4; c++) begin
			ctrl.mode_load(3'h1, 14'(c) << 3);
			pattern_read(14'h0000, 8, 6 + al[c], 1'b0);
		end
		ctrl.mode_load(3'h0, 14'h0000);
		ctrl.mode_load(3'h1, 14'h0000);
	endtask

	task automatic t_reserved_exit;
		logic [15:0] d;
		for (int s = 1; s < 4; s++) begin
			ctrl.mode_load(3'h3, 14'h0004 | 14'(s));
			pattern_read(14'h0000, 0, 5, 1'b0);
		end
		ctrl.mode_load(3'h3, 14'h0000);
		// A non-read command must leave the lanes quiet
		ctrl.issue(4'h3, 3'h0, 14'h0000);
		pattern_read(14'h0000, 0, 5, 1'b0);
		reg_read(REG_STATUS, d);
		check({15'h0, d[0]}, 16'h0000);
	endtask

	// ------------
	// Run control
	// ------------
	task automatic summarize;
		$display("checks=%0d errors=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#100000;
		error_cnt++;
		summarize();
	end

	initial begin
		rstn      = 1'b0;
		reg_addr  = '0;
		reg_wdata = '0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		error_cnt = 0;
		checked   = 0;
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		t_reset_regs();
		t_mode_select();
		t_full_burst();
		t_chop();
		t_latency();
		t_reserved_exit();
		summarize();
	end
endmodule
